// ---- logic/csirq_glue.sv ----
// chip-select decode, interrupt steering and output gating glue
// Functional notes
// - in extended parallel modes, parallel interrupt pulses low once, then releases
// - first disk select asserts for any of eight command-block addresses except 377h and 3f7h
// - second disk select asserts for the alternate status address
// - alternate infrared selection turns disk selects into second ir rx/tx
// - external interrupt goes to the configured one of lines a..f or h; line g is never selected
// - each line carries only the selected source, internal or external
// - power-good low floats every output except ring indicate and ir2 rx data, and freezes the shared-pulse state
// - joystick select low when address with aen low matches base
// - general decode low inside configured 1, 8 or 16 byte block
// - disk decoder ignores 377h and 3f7h
// - serial interrupts and ring indicate stay live regardless of power-down
// - disk enable low when disk enabled and address hits its registers
// - alternate status decoded only with low nibble 0110b
// - four-bit selector: 1..6 lines a..f, 8 line h, 0, 7 or 9..15 none
// - unselected interrupt lines float
`timescale 1ns/1ns
module csirq_glue
  import csirq_pkg::*;
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // power
  input  wire logic                       power_good,
  input  wire logic                       serial_power_down,
  // host bus
  input  wire csirq_pkg::csirq_bus_s      host_bus,
  // configuration
  input  wire csirq_pkg::csirq_decode_cfg_s decode_cfg,
  input  wire csirq_pkg::csirq_irq_cfg_s  irq_cfg,
  // interrupt sources
  input  wire logic                       fdc_irq,
  input  wire logic                       par_irq,
  input  wire logic                       ser1_irq,
  input  wire logic                       ser2_irq,
  input  wire logic                       external_irq_in,
  input  wire logic                       ring_indicate,
  // alternate infrared
  input  wire logic                       ir2_tx_data,
  output logic                            ir2_rx_data,
  // disk pins, two-way because of the infrared sharing
  input  wire logic                       cmd_pin_in,
  output logic                            disk_cmd_block_select_n,
  output logic                            disk_cmd_block_select_oe,
  output logic                            disk_alt_status_select_n,
  output logic                            disk_alt_status_select_oe,
  output logic                            disk_if_enable_n,
  output logic                            disk_if_enable_oe,
  // decode outputs
  output logic                            joystick_port_select_n,
  output logic                            joystick_port_select_oe,
  output logic                            general_decode_out_n,
  output logic                            general_decode_out_oe,
  // interrupt lines
  output csirq_pkg::csirq_irq_pins_s      irq_lines_a_to_h,
  output logic                            ring_indicate_out
);
  import csirq_pkg::*;

  logic pg_s;
  logic ext_irq_s;
  logic ir_rx_s;
  logic par_s;

  // external levels pass two flops before use
  csirq_sync u_sync_pg  (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(power_good),      .q(pg_s));
  csirq_sync u_sync_ext (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(external_irq_in), .q(ext_irq_s));
  csirq_sync u_sync_irx (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(cmd_pin_in),      .q(ir_rx_s));
  csirq_sync u_sync_par (.sys_clk(sys_clk), .sys_rst(sys_rst), .d(par_irq),         .q(par_s));

  // ---------------- address decode, no clock in the path ----------------
  logic              host_io;
  logic              skip_addr;
  logic              hit_cmd;
  logic              hit_alt;
  logic              hit_joy;
  logic              hit_gen;
  logic [ADDR_W-1:0] a;

  assign a         = host_bus.addr;
  assign host_io   = !host_bus.aen;
  assign skip_addr = (a == DISK_SKIP_A) || (a == DISK_SKIP_B);
  assign hit_cmd   = host_io && decode_cfg.disk_en && !skip_addr
                     && (a[ADDR_W-1:3] == decode_cfg.disk_cmd_base[ADDR_W-1:3]);
  assign hit_alt   = host_io && decode_cfg.disk_en && !skip_addr
                     && (a[ADDR_W-1:4] == decode_cfg.disk_alt_base[ADDR_W-1:4])
                     && (a[3:0] == ALT_STAT_NIB);
  assign hit_joy   = host_io && (a == decode_cfg.joystick_base_config);

  always_comb begin
    hit_gen = 1'b0;
    if (host_io && decode_cfg.gen_en) begin
      case (decode_cfg.gen_size)
        GEN_SZ_1:  hit_gen = (a == decode_cfg.gen_base);
        GEN_SZ_8:  hit_gen = (a[ADDR_W-1:3] == decode_cfg.gen_base[ADDR_W-1:3]);
        GEN_SZ_16: hit_gen = (a[ADDR_W-1:4] == decode_cfg.gen_base[ADDR_W-1:4]);
        default:   hit_gen = 1'b0;
      endcase
    end
  end

  // disk pins swap to infrared when the alternate pins are chosen
  always_comb begin
    if (decode_cfg.alt_ir_sel) begin
      disk_cmd_block_select_n  = 1'b1;
      disk_cmd_block_select_oe = 1'b0;
      disk_alt_status_select_n = ir2_tx_data;
      disk_alt_status_select_oe = pg_s;
      disk_if_enable_n         = 1'b1;
      disk_if_enable_oe        = 1'b0;
    end else begin
      disk_cmd_block_select_n  = !hit_cmd;
      disk_cmd_block_select_oe = pg_s;
      disk_alt_status_select_n = !hit_alt;
      disk_alt_status_select_oe = pg_s;
      disk_if_enable_n         = !(hit_cmd || hit_alt);
      disk_if_enable_oe        = pg_s;
    end
  end

  // receive only counts while the pin is an input
  assign ir2_rx_data = decode_cfg.alt_ir_sel ? ir_rx_s : 1'b0;

  assign joystick_port_select_n  = !hit_joy;
  assign joystick_port_select_oe = pg_s;
  assign general_decode_out_n    = !hit_gen;
  assign general_decode_out_oe   = pg_s;

  // ---------------- shared parallel interrupt pulse ----------------
  typedef enum logic [1:0] {
    CSIRQ_SH_IDLE  = 2'b00,
    CSIRQ_SH_PULSE = 2'b01,
    CSIRQ_SH_WAIT  = 2'b10
  } csirq_share_e;

  csirq_share_e share_q;
  logic         pulse_act;
  logic         shared_mode;

  assign shared_mode = (irq_cfg.pio_mode == CSIRQ_PIO_ECP) || (irq_cfg.pio_mode == CSIRQ_PIO_EPP);

  // state freezes while power is bad so nothing is lost
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      share_q <= CSIRQ_SH_IDLE;
    end else if (pg_s) begin
      case (share_q)
        CSIRQ_SH_IDLE:  if (shared_mode && par_s) share_q <= CSIRQ_SH_PULSE;
        CSIRQ_SH_PULSE: share_q <= CSIRQ_SH_WAIT;
        CSIRQ_SH_WAIT:  if (!par_s) share_q <= CSIRQ_SH_IDLE;
        default:        share_q <= CSIRQ_SH_IDLE;
      endcase
    end
  end

  assign pulse_act = (share_q == CSIRQ_SH_PULSE);

  // ---------------- interrupt steering ----------------
  logic [NUM_SRC-1:0] src_lvl;
  logic [NUM_SRC-1:0] src_share;
  logic [NUM_IRQ-1:0] sel_hot;

  always_comb begin
    src_lvl   = {ext_irq_s, ser2_irq, ser1_irq, par_s, fdc_irq};
    src_share = {NUM_SRC{1'b0}};
    src_share[1] = shared_mode;
  end

  function automatic logic [NUM_IRQ-1:0] sel_decode(input logic [3:0] sel);
    logic [NUM_IRQ-1:0] hot;
    hot = {NUM_IRQ{1'b0}};
    if (sel == IRQ_SEL_LINE_H) begin
      hot[IRQ_LINE_H_IDX] = 1'b1;
    end else if (sel != IRQ_SEL_NONE0 && sel != IRQ_SEL_NONE7 && sel < IRQ_SEL_NONE7) begin
      hot[sel[2:0] - 3'h1] = 1'b1;
    end
    return hot;
  endfunction

  // serial sources are never gated by power-down; ring indicate passes straight on
  assign ring_indicate_out = ring_indicate;

  always_comb begin
    irq_lines_a_to_h.o  = {NUM_IRQ{1'b0}};
    irq_lines_a_to_h.oe = {NUM_IRQ{1'b0}};
    sel_hot             = {NUM_IRQ{1'b0}};
    // later sources overwrite earlier ones, so the highest source index wins a shared line
    for (int s = 0; s < NUM_SRC; s++) begin
      sel_hot = sel_decode(irq_cfg.sel[s]);
      for (int l = 0; l < NUM_IRQ; l++) begin
        if (sel_hot[l]) begin
          if (src_share[s]) begin
            irq_lines_a_to_h.o[l]  = 1'b0;
            irq_lines_a_to_h.oe[l] = pulse_act && pg_s;
          end else begin
            irq_lines_a_to_h.o[l]  = src_lvl[s];
            irq_lines_a_to_h.oe[l] = pg_s;
          end
        end
      end
    end
  end

  logic unused_pd;
  assign unused_pd = serial_power_down;
endmodule // csirq_glue

// ---- logic/csirq_pkg.sv ----
// package: constants and carrier types for the chip-select and interrupt steering glue
package csirq_pkg;
  localparam int          ADDR_W         = 10;
  localparam int          NUM_IRQ        = 8;
  localparam int          NUM_SRC        = 5;
  // interrupt selector codes, one nibble each
  localparam logic [3:0]  IRQ_SEL_NONE0  = 4'h0;
  localparam logic [3:0]  IRQ_SEL_NONE7  = 4'h7;
  localparam logic [3:0]  IRQ_SEL_LINE_H = 4'h8;
  localparam int          IRQ_LINE_H_IDX = 7;
  // alternate status low nibble
  localparam logic [3:0]  ALT_STAT_NIB   = 4'h6;
  // addresses the disk decoder never answers
  localparam logic [9:0]  DISK_SKIP_A    = 10'h377;
  localparam logic [9:0]  DISK_SKIP_B    = 10'h3f7;
  // general decode block sizes
  localparam logic [1:0]  GEN_SZ_1       = 2'h0;
  localparam logic [1:0]  GEN_SZ_8       = 2'h1;
  localparam logic [1:0]  GEN_SZ_16      = 2'h2;
  // shared-interrupt pulse length in device clocks
  localparam int          SHARE_PULSE_CYC = 1;
  localparam logic [3:0]  CFG_RST_SEL    = 4'h0;

  typedef enum logic [1:0] {
    CSIRQ_PIO_UNI = 2'b00,
    CSIRQ_PIO_ECP = 2'b01,
    CSIRQ_PIO_EPP = 2'b10,
    CSIRQ_PIO_OFF = 2'b11
  } csirq_pio_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              aen;
  } csirq_bus_s;

  typedef struct packed {
    logic              disk_en;
    logic              alt_ir_sel;
    logic [ADDR_W-1:0] disk_cmd_base;
    logic [ADDR_W-1:0] disk_alt_base;
    logic [ADDR_W-1:0] joystick_base_config;
    logic [ADDR_W-1:0] gen_base;
    logic [1:0]        gen_size;
    logic              gen_en;
  } csirq_decode_cfg_s;

  // selectors: 0 fdc, 1 parallel, 2 serial1, 3 serial2, 4 external
  typedef struct packed {
    logic [NUM_SRC-1:0][3:0] sel;
    csirq_pio_mode_e         pio_mode;
  } csirq_irq_cfg_s;

  typedef struct packed {
    logic [NUM_IRQ-1:0] o;
    logic [NUM_IRQ-1:0] oe;
  } csirq_irq_pins_s;
endpackage

// ---- logic/csirq_sync.sv ----
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module csirq_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // csirq_sync

// ---- testbench/csirq_glue_assertions.sv ----
// checker: decode and interrupt timing seen at the glue ports
`timescale 1ns/1ns
module csirq_glue_assertions
  import csirq_pkg::*;
(
  // clock, reset, power
  input wire logic                         sys_clk,
  input wire logic                         sys_rst,
  input wire logic                         power_good,
  // host side and configuration
  input wire csirq_pkg::csirq_bus_s        host_bus,
  input wire csirq_pkg::csirq_decode_cfg_s decode_cfg,
  input wire csirq_pkg::csirq_irq_cfg_s    irq_cfg,
  input wire logic                         external_irq_in,
  // device outputs
  input wire logic                         disk_cmd_block_select_n,
  input wire logic                         disk_alt_status_select_n,
  input wire logic                         joystick_port_select_n,
  input wire logic                         joystick_port_select_oe,
  input wire logic                         general_decode_out_n,
  input wire csirq_pkg::csirq_irq_pins_s   irq_lines_a_to_h
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic [9:0] a = host_bus.addr;
  // decode is judged only once power good has passed the synchroniser
  wire logic on = !host_bus.aen && !decode_cfg.alt_ir_sel && joystick_port_select_oe;
  wire logic skip = a == DISK_SKIP_A || a == DISK_SKIP_B;
  wire logic shr = irq_cfg.pio_mode inside {CSIRQ_PIO_ECP, CSIRQ_PIO_EPP} && irq_cfg.sel == 20'h00010;
  // the external source has the highest index, so it owns line a whatever else is selected
  wire logic ext_a = irq_cfg.sel[4] == 4'h1;
  a_cmd_hit: assert property (on && decode_cfg.disk_en && !skip &&
    a[9:3] == decode_cfg.disk_cmd_base[9:3] |-> !disk_cmd_block_select_n) else $error("cmd select missing");
  a_skip_addr: assert property (on && skip |-> disk_cmd_block_select_n && disk_alt_status_select_n)
    else $error("disk select on skipped address");
  a_alt_nibble: assert property (on && !disk_alt_status_select_n |-> a[3:0] == ALT_STAT_NIB)
    else $error("alt select off nibble");
  a_joy_hit: assert property (on && a == decode_cfg.joystick_base_config |-> !joystick_port_select_n)
    else $error("joystick select missing");
  a_aen_quiet: assert property (host_bus.aen |-> joystick_port_select_n && general_decode_out_n)
    else $error("decode during aen");
  a_pg_float: assert property (!power_good |-> ##2 !joystick_port_select_oe && irq_lines_a_to_h.oe == 8'h0)
    else $error("outputs driven without power good");
  a_ext_route: assert property (ext_a && irq_lines_a_to_h.oe[0] |->
    irq_lines_a_to_h.o[0] == $past(external_irq_in, 2)) else $error("external interrupt not routed");
  a_share_pulse: assert property (shr && $rose(irq_lines_a_to_h.oe[0]) |->
    !irq_lines_a_to_h.o[0] ##1 !irq_lines_a_to_h.oe[0]) else $error("shared pulse wrong");
  c_cmd: cover property (on && !disk_cmd_block_select_n);
  c_pulse: cover property (shr && $rose(irq_lines_a_to_h.oe[0]));
  c_pg_low: cover property (!power_good);
endmodule  // csirq_glue_assertions

bind csirq_glue csirq_glue_assertions u_chk (.sys_clk, .sys_rst, .power_good, .host_bus, .decode_cfg, .irq_cfg,
  .external_irq_in, .disk_cmd_block_select_n, .disk_alt_status_select_n, .joystick_port_select_n,
  .joystick_port_select_oe, .general_decode_out_n, .irq_lines_a_to_h);

// ---- testbench/csirq_host_model.sv ----
// host-side interrupt controller inputs with board pull-ups
`timescale 1ns/1ns
module csirq_host_model
  import csirq_pkg::*;
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // lines from the device
  input  wire csirq_pkg::csirq_irq_pins_s irq_lines_a_to_h,
  // resolved levels, low cycles seen on line a
  output logic [7:0]                      irq_level,
  output int                              irq_low_cnt
);
  // a released line reads high, so a shared pulse shows as low cycles
  assign irq_level = irq_lines_a_to_h.o | ~irq_lines_a_to_h.oe;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) irq_low_cnt <= 0;
    else if (!irq_level[0]) irq_low_cnt <= irq_low_cnt + 1;
  end
endmodule  // csirq_host_model

// ---- testbench/test_csirq_glue.sv ----
// self-checking bench for the chip-select and interrupt glue
`timescale 1ns/1ns
module test_csirq_glue;
  import csirq_pkg::*;
  logic sys_clk, sys_rst, power_good, serial_power_down, fdc_irq, par_irq, ser1_irq, ser2_irq, external_irq_in;
  logic ring_indicate, ir2_tx_data, cmd_pin_in, ir2_rx_data, ring_indicate_out, disk_if_enable_n, disk_if_enable_oe;
  logic disk_cmd_block_select_n, disk_cmd_block_select_oe, disk_alt_status_select_n, disk_alt_status_select_oe;
  logic joystick_port_select_n, joystick_port_select_oe, general_decode_out_n, general_decode_out_oe;
  csirq_bus_s        host_bus;
  csirq_decode_cfg_s decode_cfg;
  csirq_irq_cfg_s    irq_cfg;
  csirq_irq_pins_s   irq_lines_a_to_h;
  logic [7:0]        irq_level;
  int                num_errors, check_count, irq_low_cnt, lows;
  // rows: aen, addr, expected cmd, alt, joystick, general selects
  logic [15:0] rows [11] = '{16'h3707, 16'h377f, 16'h378f, 16'h3f6b, 16'h3f7f, 16'h3f5f,
                             16'h201d, 16'h601f, 16'h307e, 16'h308f, 16'h300e};
  logic [13:0] gt [6] = '{{1'b1, GEN_SZ_1, 10'h300, 1'b0}, {1'b1, GEN_SZ_1, 10'h301, 1'b1},
    {1'b1, GEN_SZ_16, 10'h30f, 1'b0}, {1'b1, GEN_SZ_16, 10'h310, 1'b1}, {1'b1, 2'h3, 10'h300, 1'b1},
    {1'b0, GEN_SZ_8, 10'h300, 1'b1}};
  csirq_pio_mode_e md [2] = '{CSIRQ_PIO_ECP, CSIRQ_PIO_EPP};
  csirq_glue dut (.sys_clk, .sys_rst, .power_good, .serial_power_down, .host_bus, .decode_cfg, .irq_cfg,
    .fdc_irq, .par_irq, .ser1_irq, .ser2_irq, .external_irq_in, .ring_indicate, .ir2_tx_data, .ir2_rx_data,
    .cmd_pin_in, .disk_cmd_block_select_n, .disk_cmd_block_select_oe, .disk_alt_status_select_n,
    .disk_alt_status_select_oe, .disk_if_enable_n, .disk_if_enable_oe, .joystick_port_select_n,
    .joystick_port_select_oe, .general_decode_out_n, .general_decode_out_oe, .irq_lines_a_to_h, .ring_indicate_out);
  csirq_host_model host (.sys_clk, .sys_rst, .irq_lines_a_to_h, .irq_level, .irq_low_cnt);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  // the whole sequence needs about 130 cycles
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  wire logic [5:0] oes = {joystick_port_select_oe, general_decode_out_oe, disk_cmd_block_select_oe,
                          disk_alt_status_select_oe, disk_if_enable_oe, |irq_lines_a_to_h.oe};
  initial begin
    {sys_rst, power_good, serial_power_down, fdc_irq, par_irq, ser1_irq, ser2_irq} = 7'h70;
    {external_irq_in, ring_indicate, ir2_tx_data, cmd_pin_in} = 4'h0;
    host_bus = '0;
    decode_cfg = '{1'b1, 1'b0, 10'h370, 10'h3f6, 10'h201, 10'h300, GEN_SZ_8, 1'b1};
    irq_cfg = '0;
    cyc(5);
    chk(oes, 0);
    @(posedge sys_clk) sys_rst <= 0;
    cyc(3);
    foreach (rows[i]) begin
      @(posedge sys_clk) host_bus <= {rows[i][13:4], rows[i][14]};
      cyc(0);
      chk({disk_cmd_block_select_n, disk_alt_status_select_n, joystick_port_select_n, general_decode_out_n,
           disk_if_enable_n}, {rows[i][3:0], &rows[i][3:2]});
    end
    foreach (gt[i]) begin
      @(posedge sys_clk) {decode_cfg.gen_en, decode_cfg.gen_size, host_bus} <= {gt[i][13:1], 1'b0};
      cyc(0);
      chk(general_decode_out_n, gt[i][0]);
    end
    @(posedge sys_clk) {decode_cfg.alt_ir_sel, host_bus, ir2_tx_data, cmd_pin_in} <= {1'b1, 10'h370, 3'h3};
    cyc(3);
    chk({disk_cmd_block_select_oe, disk_alt_status_select_n, ir2_rx_data}, 3'b011);
    @(posedge sys_clk) {ir2_tx_data, cmd_pin_in} <= 2'b00;
    cyc(3);
    chk({disk_cmd_block_select_oe, disk_alt_status_select_n, ir2_rx_data}, 3'b000);
    @(posedge sys_clk) {decode_cfg.alt_ir_sel, external_irq_in} <= 2'b01;
    for (int c = 0; c < 10; c++) begin
      @(posedge sys_clk) irq_cfg.sel[4] <= c[3:0];
      cyc(3);
      chk(irq_lines_a_to_h.oe, c inside {[1:6]} ? 8'(1 << (c - 1)) : c == 8 ? 8'h80 : 8'h0);
      chk(irq_level, 8'hff);
    end
    // fdc on b, serial 1 on c with power-down set, external on a
    @(posedge sys_clk) {irq_cfg.sel, fdc_irq, ser1_irq, external_irq_in, ring_indicate} <= {20'h10302, 4'hd};
    cyc(3);
    chk({ring_indicate_out, irq_lines_a_to_h.oe, irq_level}, 17'h107fe);
    @(posedge sys_clk) {fdc_irq, ser1_irq, external_irq_in, ring_indicate} <= 4'h2;
    cyc(3);
    chk({ring_indicate_out, irq_lines_a_to_h.oe, irq_level}, 17'h007f9);
    foreach (md[i]) begin
      @(posedge sys_clk) {irq_cfg, par_irq} <= {20'h00010, md[i], 1'b0};
      cyc(3);
      lows = irq_low_cnt;
      @(posedge sys_clk) par_irq <= 1;
      cyc(8);
      chk(irq_low_cnt - lows, 1);
      chk(irq_lines_a_to_h.oe, 0);
    end
    @(posedge sys_clk) {irq_cfg.pio_mode, host_bus} <= {CSIRQ_PIO_UNI, 10'h201, 1'b0};
    cyc(3);
    chk({irq_lines_a_to_h.oe[0], irq_level[0]}, 2'b11);
    @(posedge sys_clk) power_good <= 0;
    cyc(3);
    chk(oes, 0);
    @(posedge sys_clk) power_good <= 1;
    cyc(3);
    chk({joystick_port_select_oe, joystick_port_select_n, irq_lines_a_to_h.oe[0]}, 3'b101);
    chk(oes, 6'h3f);
    // reset in mid-run: outputs float at once and come back two clocks after release
    @(posedge sys_clk) sys_rst <= 1;
    cyc(1);
    chk(oes, 0);
    @(posedge sys_clk) sys_rst <= 0;
    cyc(1);
    chk(oes, 0);
    cyc(2);
    chk(oes, 6'h3f);
    final_report();
  end
endmodule  // test_csirq_glue
